// ---- hdl/sac_pkg.sv ----
/*
  Shared constants and types of the converter control block.
  Assumes one clock at the crystal rate; four clocks make a machine cycle.
*/
package sac_pkg;

  // ******************************
  // Register map
  // ******************************
  localparam int          SAC_ADDR_W    = 8;
  localparam int          SAC_DATA_W    = 8;
  localparam logic [7:0]  SAC_REG_CTRL  = 8'hc0;
  localparam logic [7:0]  SAC_REG_RESLO = 8'hc1;
  localparam logic [7:0]  SAC_REG_RESHI = 8'hc2;
  localparam logic [7:0]  SAC_REG_PINSW = 8'hc6;

  // ******************************
  // Field positions
  // ******************************
  localparam int SAC_CTRL_ON    = 7;
  localparam int SAC_CTRL_EXT   = 5;
  localparam int SAC_CTRL_FLAG  = 4;
  localparam int SAC_CTRL_START = 3;
  localparam int SAC_CHAN_LSB   = 0;
  localparam int SAC_CHAN_W     = 3;
  localparam int SAC_CLK_LSB    = 6;
  localparam int SAC_RES_W      = 10;

  // ******************************
  // Reset values and encodings
  // ******************************
  localparam logic [1:0] SAC_CLKSEL_RST = 2'h0;
  localparam logic [7:0] SAC_PINSW_RST  = 8'h00;
  localparam logic [1:0] SAC_DIV4       = 2'h0;
  localparam logic [1:0] SAC_DIV8       = 2'h1;
  localparam logic [3:0] SAC_DIV4_LAST  = 4'h3;
  localparam logic [3:0] SAC_DIV8_LAST  = 4'h7;
  localparam logic [3:0] SAC_DIV16_LAST = 4'hf;

  // ******************************
  // Timing
  // ******************************
  localparam int SAC_MC_CLKS = 4;
  localparam int SAC_CONV_MC = 50;

  // ******************************
  // Types
  // ******************************
  typedef enum logic [1:0] {
    SAC_IDLE  = 2'b00,
    SAC_ALIGN = 2'b01,
    SAC_CONV  = 2'b11
  } sac_state_t;

  typedef struct packed {
    logic                  on;
    logic [SAC_CHAN_W-1:0] chan;
    logic                  sample;
    logic [SAC_RES_W-1:0]  dac;
  } sac_ana_t;

  typedef struct packed {
    logic [3:0] cnt;
  } sac_div_st_t;

  typedef struct packed {
    logic                 busy;
    logic [3:0]           bitIdx;
    logic [SAC_RES_W-1:0] trial;
    logic [SAC_RES_W-1:0] result;
  } sac_sar_st_t;

  typedef struct packed {
    sac_state_t            state;
    logic                  on;
    logic                  extAllow;
    logic                  flag;
    logic                  start;
    logic [SAC_CHAN_W-1:0] chan;
    logic [SAC_CHAN_W-1:0] convChan;
    logic [1:0]            clkSel;
    logic [7:0]            pinSw;
    logic [SAC_RES_W-1:0]  result;
    logic [1:0]            mcCnt;
    logic [5:0]            convCnt;
    logic                  extPrev;
    logic [7:0]            rdData;
  } sac_ctrl_st_t;

endpackage

// ---- hdl/sac_clk_div.sv ----
/*
  Converter clock divider: one-cycle tick every 4, 8 or 16 clocks.
  Assumes the clock is the crystal clock; run low holds the phase at zero.
*/
`timescale 1ns/1ps
module sac_clk_div
  import sac_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);

  sac_div_st_t cur_ff;
  sac_div_st_t nxt_cur;

  // Reserved code runs at the slowest rate, the safe side of the clock limit
  function automatic logic [3:0] divLast(input logic [1:0] s);
    if (s == SAC_DIV4) begin
      divLast = SAC_DIV4_LAST;
    end else if (s == SAC_DIV8) begin
      divLast = SAC_DIV8_LAST;
    end else begin
      divLast = SAC_DIV16_LAST;
    end
  endfunction

  assign tick = run && (cur_ff.cnt == divLast(sel));

  always_comb begin
    nxt_cur = cur_ff;
    if (!run || tick) begin
      nxt_cur.cnt = 4'h0;
    end else begin
      nxt_cur.cnt = cur_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

endmodule // sac_clk_div

// ---- hdl/sac_sar_core.sv ----
/*
  Successive-approximation register: one trial bit per converter clock tick.
  Assumes the comparator reads high while the input is at or above the DAC.
*/
`timescale 1ns/1ps
module sac_sar_core
  import sac_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic                 go,
  input  wire logic                 abort,
  input  wire logic                 step,
  input  wire logic                 compHigh,
  output logic                      busy,
  output logic [SAC_RES_W-1:0]      dacCode,
  output logic [SAC_RES_W-1:0]      result
);

  sac_sar_st_t cur_ff;
  sac_sar_st_t nxt_cur;
  logic [SAC_RES_W-1:0] kept;

  function automatic logic [SAC_RES_W-1:0] oneHot(input logic [3:0] idx);
    oneHot = '0;
    oneHot[idx] = 1'b1;
  endfunction

  assign busy    = cur_ff.busy;
  assign dacCode = cur_ff.trial;
  assign result  = cur_ff.result;

  always_comb begin
    nxt_cur = cur_ff;
    kept    = compHigh ? cur_ff.trial : (cur_ff.trial & ~oneHot(cur_ff.bitIdx));
    if (abort) begin
      nxt_cur.busy = 1'b0;
    end else if (go) begin
      nxt_cur.busy   = 1'b1;
      nxt_cur.bitIdx = 4'(SAC_RES_W - 1);
      nxt_cur.trial  = oneHot(4'(SAC_RES_W - 1));
    end else if (cur_ff.busy && step) begin
      if (cur_ff.bitIdx == 4'h0) begin
        // Code pins at all-zero or all-one at the rails by construction
        nxt_cur.result = kept;
        nxt_cur.trial  = kept;
        nxt_cur.busy   = 1'b0;
      end else begin
        nxt_cur.trial  = kept | oneHot(cur_ff.bitIdx - 4'h1);
        nxt_cur.bitIdx = cur_ff.bitIdx - 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

endmodule // sac_sar_core

// ---- hdl/sac_ctrl.sv ----
/*
  Converter control top: registers, start logic, conversion timing.
  Assumes a register port with read data one cycle after the read strobe,
  an external comparator and ladder DAC, and a power-down level from the CPU.
*/
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - Converter runs only while the enable bit is one.
// - Three-bit channel code 0..7 routes input 0..7 to the converter.
// - Software writing one to start begins converting the selected channel.
// - With external start allowed, a pin rising edge also sets start.
// - Edge seen at machine cycle end; conversion begins next machine cycle.
// - Conversion lasts 50 machine cycles, then the complete flag sets.
// - Upper eight result bits in result high, two low bits separately.
// - Start requests during a conversion are ignored.
// - Power-down aborts a conversion; completed result and flag stay.
// - Eight-bit pin switch picks digital or analog per shared pin.
// - Code is 1024 times input over supply, saturating at the rails.
// - Completion sets the flag, an interrupt request; only software clears.
// - Start reads one during conversion and clears itself on completion.
// - While the flag is one no new conversion may start.
// - Clock select divides crystal clock by 4, 8 or 16; 11 reserved.
// - Result high and the two low result bits are read-only.
// - Pin switch bit one means analog input, zero digital I/O.
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int MC_CLKS = SAC_MC_CLKS,
  parameter int CONV_MC = SAC_CONV_MC
)(
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic                  ce,
  input  wire logic [SAC_ADDR_W-1:0] addr,
  input  wire logic [SAC_DATA_W-1:0] wrData,
  input  wire logic                  wrStb,
  input  wire logic                  rdStb,
  output logic      [SAC_DATA_W-1:0] rdData,
  input  wire logic                  extStartPin,
  input  wire logic                  powerDown,
  input  wire logic                  compHigh,
  output sac_ana_t                   anaOut,
  output logic      [7:0]            pinAnalog,
  output logic                       completeFlag,
  output logic                       convBusy
);

  // ******************************
  // Elaboration checks
  // ******************************
  // Counters are sized for at most four clocks per machine cycle and
  // 63 machine cycles; the window must also cover a full slow SAR pass.
  if (MC_CLKS < 2 || MC_CLKS > 4) begin : gBadMc
    $error("sac_ctrl: MC_CLKS out of range");
  end
  if (CONV_MC > 63 || CONV_MC * MC_CLKS < 16 * (SAC_RES_W + 1)) begin : gBadConv
    $error("sac_ctrl: CONV_MC cannot serve the converter");
  end

  localparam logic [1:0] MC_LAST   = 2'(MC_CLKS - 1);
  localparam logic [5:0] CONV_LAST = 6'(CONV_MC - 1);

  // ******************************
  // State
  // ******************************
  sac_ctrl_st_t               cur_ff;
  sac_ctrl_st_t               nxt_cur;
  logic                       mcTick;
  logic                       extRise;
  logic                       canStart;
  logic                       swStart;
  logic                       ctrlWr;
  logic                       reslWr;
  logic                       pinWr;
  logic                       abortConv;
  logic                       finish;
  logic                       sarGo;
  logic                       sarBusy;
  logic                       convTick;
  logic [SAC_RES_W-1:0]       sarDac;
  logic [SAC_RES_W-1:0]       sarResult;

  // ******************************
  // Converter clock and SAR
  // ******************************
  sac_clk_div u_div (
    .clock (clock),
    .srst  (srst),
    .ce    (ce),
    .run   (sarBusy),
    .sel   (cur_ff.clkSel),
    .tick  (convTick)
  );

  sac_sar_core u_sar (
    .clock    (clock),
    .srst     (srst),
    .ce       (ce),
    .go       (sarGo),
    .abort    (abortConv),
    .step     (convTick),
    .compHigh (compHigh),
    .busy     (sarBusy),
    .dacCode  (sarDac),
    .result   (sarResult)
  );

  // ******************************
  // Decode
  // ******************************
  always_comb begin
    ctrlWr = 1'b0;
    reslWr = 1'b0;
    pinWr  = 1'b0;
    if (wrStb && addr == SAC_REG_CTRL) begin
      ctrlWr = 1'b1;
    end else if (wrStb && addr == SAC_REG_RESLO) begin
      reslWr = 1'b1;
    end else if (wrStb && addr == SAC_REG_PINSW) begin
      pinWr = 1'b1;
    end
  end

  // ******************************
  // Start and timing terms
  // ******************************
  assign mcTick = (cur_ff.mcCnt == MC_LAST);

  // Pin level is sampled once per machine cycle, so a pulse shorter than
  // one machine cycle on either side may be missed
  assign extRise = mcTick && cur_ff.extAllow && !cur_ff.extPrev && extStartPin;

  // Idle, enabled, awake and the complete flag clear
  assign canStart = (cur_ff.state == SAC_IDLE) && cur_ff.on && !cur_ff.flag && !powerDown;

  assign swStart = ctrlWr && wrData[SAC_CTRL_START];

  assign abortConv = (cur_ff.state != SAC_IDLE) && (powerDown || !cur_ff.on);

  assign finish = (cur_ff.state == SAC_CONV) && mcTick && (cur_ff.convCnt == CONV_LAST) && !abortConv;

  assign sarGo = (cur_ff.state != SAC_CONV) && (nxt_cur.state == SAC_CONV);

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    nxt_cur = cur_ff;

    // Machine cycle phase
    nxt_cur.mcCnt = mcTick ? 2'h0 : cur_ff.mcCnt + 2'h1;
    if (mcTick) begin
      nxt_cur.extPrev = extStartPin;
    end

    // Control register writes
    if (ctrlWr) begin
      nxt_cur.on       = wrData[SAC_CTRL_ON];
      nxt_cur.extAllow = wrData[SAC_CTRL_EXT];
      nxt_cur.chan     = wrData[SAC_CHAN_LSB +: SAC_CHAN_W];
      // Writing one to the flag has no effect; writing zero clears it
      if (!wrData[SAC_CTRL_FLAG]) begin
        nxt_cur.flag = 1'b0;
      end
    end
    if (reslWr) begin
      nxt_cur.clkSel = wrData[SAC_CLK_LSB +: 2];
    end
    if (pinWr) begin
      nxt_cur.pinSw = wrData;
    end

    // Conversion sequence
    case (cur_ff.state)
      SAC_IDLE: begin
        if (canStart && extRise) begin
          // Edge seen at this machine cycle end; next cycle opens the next one
          nxt_cur.start    = 1'b1;
          nxt_cur.state    = SAC_CONV;
          nxt_cur.convCnt  = 6'h00;
          nxt_cur.convChan = cur_ff.chan;
        end else if (canStart && swStart) begin
          nxt_cur.start = 1'b1;
          nxt_cur.state = SAC_ALIGN;
        end
      end
      SAC_ALIGN: begin
        // Software start waits for a machine cycle boundary
        if (mcTick) begin
          nxt_cur.state    = SAC_CONV;
          nxt_cur.convCnt  = 6'h00;
          nxt_cur.convChan = cur_ff.chan;
        end
      end
      SAC_CONV: begin
        if (finish) begin
          nxt_cur.result = sarResult;
          nxt_cur.flag   = 1'b1;
          nxt_cur.start  = 1'b0;
          nxt_cur.state  = SAC_IDLE;
        end else if (mcTick) begin
          nxt_cur.convCnt = cur_ff.convCnt + 6'h01;
        end
      end
      default: begin
        nxt_cur.state = SAC_IDLE;
      end
    endcase

    // Abort leaves result and flag untouched
    if (abortConv) begin
      nxt_cur.state = SAC_IDLE;
      nxt_cur.start = 1'b0;
    end

    // Read data stands only in the cycle after the strobe
    nxt_cur.rdData = 8'h00;
    if (rdStb) begin
      if (addr == SAC_REG_CTRL) begin
        nxt_cur.rdData = {cur_ff.on, 1'b0, cur_ff.extAllow, cur_ff.flag, cur_ff.start, cur_ff.chan};
      end else if (addr == SAC_REG_RESLO) begin
        nxt_cur.rdData = {cur_ff.clkSel, 4'h0, cur_ff.result[1:0]};
      end else if (addr == SAC_REG_RESHI) begin
        nxt_cur.rdData = cur_ff.result[SAC_RES_W-1:2];
      end else if (addr == SAC_REG_PINSW) begin
        nxt_cur.rdData = cur_ff.pinSw;
      end
    end
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge clock) begin
    if (srst) begin
      cur_ff        <= '0;
      cur_ff.state  <= SAC_IDLE;
      cur_ff.clkSel <= SAC_CLKSEL_RST;
      cur_ff.pinSw  <= SAC_PINSW_RST;
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  // Channel is frozen for the conversion so a rewrite cannot disturb it
  always_comb begin
    anaOut.on     = cur_ff.on;
    anaOut.chan   = (cur_ff.state == SAC_CONV) ? cur_ff.convChan : cur_ff.chan;
    anaOut.sample = sarBusy;
    anaOut.dac    = sarDac;
  end

  assign pinAnalog    = cur_ff.pinSw;
  assign completeFlag = cur_ff.flag;
  assign convBusy     = cur_ff.start;
  assign rdData       = cur_ff.rdData;

endmodule // sac_ctrl

// ---- verification/sac_ctrl_monitor.sv ----
/*
  Port checker for the converter control block.
  Assumes one clock domain with sync reset srst; bound into sac_ctrl.
*/
`timescale 1ns/1ps
module sac_ctrl_monitor
  import sac_pkg::*;
#(
  parameter int MC_CLKS = 4,
  parameter int CONV_MC = 50
)(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] rdData,
  input wire logic       extStartPin,
  input wire logic       powerDown,
  input wire logic       compHigh,
  input wire sac_ana_t   anaOut,
  input wire logic [7:0] pinAnalog,
  input wire logic       completeFlag,
  input wire logic       convBusy
);
  // ****
  // Helpers
  // ****
  localparam int LO = CONV_MC * MC_CLKS - 1;
  localparam int HI = CONV_MC * MC_CLKS + MC_CLKS;
  logic [9:0] busyLen;
  logic       clrWr;
  logic       pinWr;
  assign clrWr = ce && wrStb && addr == SAC_REG_CTRL && !wrData[SAC_CTRL_FLAG];
  assign pinWr = ce && wrStb && addr == SAC_REG_PINSW;
  // Busy run length in enabled clocks, cleared while idle so each conversion counts alone
  always_ff @(posedge clock) begin
    busyLen <= (srst || !convBusy) ? 10'h000 : (ce ? busyLen + 10'h001 : busyLen);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ****
  // Assertions
  // ****
  pin_sw_wr_a: assert property (pinWr |=> pinAnalog == $past(wrData))
    else $error("pin switch not taken from write");
  flag_sw_clr_a: assert property ($fell(completeFlag) |-> $past(clrWr))
    else $error("flag cleared without software write");
  done_same_a: assert property ($rose(completeFlag) |-> $fell(convBusy))
    else $error("flag set without start clearing");
  conv_len_a: assert property ($rose(completeFlag) |-> busyLen >= LO && busyLen <= HI)
    else $error("conversion length wrong");
  flag_blocks_a: assert property (completeFlag && !convBusy |=> !convBusy)
    else $error("start while flag set");
  off_blocks_a: assert property (!anaOut.on && !convBusy |=> !convBusy)
    else $error("start while disabled");
  pd_abort_a: assert property (powerDown && ce |=> !convBusy)
    else $error("power-down did not abort");
  chan_hold_a: assert property (anaOut.sample && $past(anaOut.sample) |-> $stable(anaOut.chan))
    else $error("channel moved during conversion");
  msb_first_a: assert property ($rose(anaOut.sample) |-> anaOut.dac == 10'h200)
    else $error("first trial is not the top bit");
  cover property ($rose(completeFlag));
  cover property (powerDown && convBusy);
  cover property ($rose(convBusy) && !$past(wrStb));
  cover property (!ce && convBusy);
endmodule // sac_ctrl_monitor

bind sac_ctrl sac_ctrl_monitor #(.MC_CLKS(MC_CLKS), .CONV_MC(CONV_MC)) mon (
  .clock(clock), .srst(srst), .ce(ce), .addr(addr), .wrData(wrData), .wrStb(wrStb),
  .rdStb(rdStb), .rdData(rdData), .extStartPin(extStartPin), .powerDown(powerDown),
  .compHigh(compHigh), .anaOut(anaOut), .pinAnalog(pinAnalog),
  .completeFlag(completeFlag), .convBusy(convBusy)
);

// ---- verification/sac_ana_model.sv ----
/*
  Comparator, ladder and input mux model: one fixed code per channel.
  Assumes the comparator is only meaningful while a conversion samples.
*/
`timescale 1ns/1ps
module sac_ana_model
  import sac_pkg::*;
(
  input wire logic        clock,
  input wire sac_ana_t    anaOut,
  input wire logic [79:0] levels,
  output logic            compHigh
);
  // ****
  // Comparator
  // ****
  logic junk = 1'b0;
  // Outside sampling the output wanders, so stale values cannot pass
  always @(posedge clock) begin
    junk <= !junk;
  end
  always_comb begin
    compHigh = anaOut.sample ? (levels[anaOut.chan * 10 +: 10] >= anaOut.dac) : junk;
  end
endmodule // sac_ana_model

// ---- verification/sac_ctrl_tb.sv ----
/*
  Self-checking bench for the converter control block.
  Assumes the analog model beside it and the checker bound into the block.
*/
`timescale 1ns/1ps
module sac_ctrl_tb
  import sac_pkg::*;
;
  // ****
  // Setup
  // ****
  localparam logic [79:0] LV = {10'h3fe, 10'h1ff, 10'h200, 10'h001, 10'h2aa, 10'h155, 10'h3ff, 10'h000};
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       wrStb = 1'b0;
  logic       rdStb = 1'b0;
  logic       extStartPin = 1'b0;
  logic       powerDown = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic [7:0] rdData;
  logic [7:0] pinAnalog;
  logic       compHigh;
  logic       completeFlag;
  logic       convBusy;
  sac_ana_t   anaOut;
  int         fail_count = 0;
  int         total_checks = 0;
  always #4 clock = ~clock;
  sac_ctrl dut (.clock(clock), .srst(srst), .ce(ce), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .extStartPin(extStartPin),
    .powerDown(powerDown), .compHigh(compHigh), .anaOut(anaOut), .pinAnalog(pinAnalog),
    .completeFlag(completeFlag), .convBusy(convBusy));
  sac_ana_model ana (.clock(clock), .anaOut(anaOut), .levels(LV), .compHigh(compHigh));
  // ****
  // Helpers
  // ****
  task report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
    #1;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1;
    chk(rdData, e);
  endtask
  task wflag(output int n);
    n = 0;
    repeat (300) begin
      @(posedge clock);
      #1;
      if (anaOut.sample === 1'b1) n++;
      if (completeFlag === 1'b1) break;
    end
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs;
    rchk(SAC_REG_CTRL, 8'h00);
    rchk(SAC_REG_RESLO, 8'h00);
    wr(SAC_REG_PINSW, 8'ha5);
    chk(pinAnalog, 8'ha5);
    rchk(SAC_REG_PINSW, 8'ha5);
    wr(SAC_REG_RESHI, 8'hff);
    rchk(SAC_REG_RESHI, 8'h00);
    rchk(8'hc3, 8'h00);
    wr(SAC_REG_CTRL, 8'h08);
    chk(convBusy, 1'b0);
  endtask
  task conv(input logic [2:0] ch);
    int n;
    int d;
    logic [9:0] e;
    logic [1:0] s;
    e = LV[ch * 10 +: 10];
    // Code 3 is reserved and falls back to the slowest divider
    s = 2'(ch % 4);
    d = (s == 2'h3) ? 16 : (4 << s);
    wr(SAC_REG_RESLO, {s, 6'h00});
    wr(SAC_REG_CTRL, {5'h10, ch});
    wr(SAC_REG_CTRL, {5'h11, ch});
    rchk(SAC_REG_CTRL, {5'h11, ch});
    chk(anaOut.chan, ch);
    wflag(n);
    chk(n >= 9 * d && n <= 11 * d, 1'b1);
    rchk(SAC_REG_CTRL, {5'h12, ch});
    rchk(SAC_REG_RESHI, e[9:2]);
    rchk(SAC_REG_RESLO, {s, 4'h0, e[1:0]});
    wr(SAC_REG_CTRL, {5'h10, ch});
    chk(completeFlag, 1'b0);
  endtask
  task t_block;
    int n;
    wr(SAC_REG_CTRL, 8'h81);
    wr(SAC_REG_CTRL, 8'h89);
    repeat (10) @(posedge clock);
    wr(SAC_REG_CTRL, 8'h8e);
    chk(convBusy, 1'b1);
    wflag(n);
    rchk(SAC_REG_RESHI, 8'hff);
    wr(SAC_REG_CTRL, 8'h9e);
    chk(convBusy, 1'b0);
    @(posedge clock);
    powerDown <= 1'b1;
    @(posedge clock);
    powerDown <= 1'b0;
    #1 chk(completeFlag, 1'b1);
    wr(SAC_REG_CTRL, 8'h86);
  endtask
  task t_ext;
    int n;
    wr(SAC_REG_CTRL, 8'ha2);
    // Pin held low two machine cycles, then high, so both levels are seen
    repeat (8) @(posedge clock);
    extStartPin <= 1'b1;
    repeat (12) @(posedge clock);
    #1 chk(convBusy, 1'b1);
    wflag(n);
    rchk(SAC_REG_RESHI, 8'h55);
    @(posedge clock);
    extStartPin <= 1'b0;
    wr(SAC_REG_CTRL, 8'h82);
    repeat (8) @(posedge clock);
    extStartPin <= 1'b1;
    repeat (12) @(posedge clock);
    #1 chk(convBusy, 1'b0);
    @(posedge clock);
    extStartPin <= 1'b0;
  endtask
  task t_pd;
    wr(SAC_REG_CTRL, 8'h83);
    wr(SAC_REG_CTRL, 8'h8b);
    repeat (20) @(posedge clock);
    // Frozen clock enable must swallow a power-down pulse
    ce <= 1'b0;
    powerDown <= 1'b1;
    @(posedge clock);
    powerDown <= 1'b0;
    @(posedge clock);
    ce <= 1'b1;
    #1 chk(convBusy, 1'b1);
    repeat (20) @(posedge clock);
    powerDown <= 1'b1;
    @(posedge clock);
    powerDown <= 1'b0;
    #1 chk(convBusy, 1'b0);
    chk(completeFlag, 1'b0);
    rchk(SAC_REG_RESHI, 8'h55);
    // An aborted conversion must never complete later
    repeat (220) @(posedge clock);
    #1 chk(completeFlag, 1'b0);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    for (int c = 0; c < 8; c++) conv(3'(c));
    t_block();
    t_ext();
    t_pd();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
endmodule // sac_ctrl_tb
